//--- verification/alarm_monitor_sva.sv
// Purpose: Port checks for the channel alarm monitor.
// Assumes: Status is seen on rdata the cycle after a status read.
// Notes:   Control is mirrored from writes; windows allow for sync lag.
module alarm_monitor_sva (
    input wire logic mclk, // clock
    input wire logic resetn, // reset
    input wire logic [7:0] addr, // index
    input wire logic [7:0] wdata, // data in
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [7:0] rdata, // data out
    input wire logic [5:0] fifo_fill, // fill
    input wire logic analog_los_pin, // analog
    input wire logic g775_los_pin, // E3 detector
    input wire logic tx_bit_tick, // tx tick
    input wire logic tx_line_positive_out, // pad
    input wire logic tx_line_negative_out // pad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctrl_q, ctrl_d;
    logic [8:0] quiet_q, quiet_d;
    logic rds, pads, inm, ja, ds3, e3;
    assign rds = rd && addr == alarm_pkg::OFF_STATUS;
    assign pads = tx_line_positive_out || tx_line_negative_out;
    assign ja = ctrl_q[alarm_pkg::CB_JA_EN];
    assign ds3 = ctrl_q[3:2] == alarm_pkg::RATE_DS3;
    assign e3 = ctrl_q[3:2] == alarm_pkg::RATE_E3;
    assign inm = fifo_fill <= 6'h02 || fifo_fill >= (ctrl_q[1] ? 6'h1E : 6'h0E);
    assign ctrl_d = (wr && addr == alarm_pkg::OFF_CTRL) ? wdata : ctrl_q;
    // Counts only in pad mode, where activity is visible to us without sync
    assign quiet_d = (pads || !ctrl_q[5]) ? 9'h000 : quiet_q + {8'h00, tx_bit_tick && !quiet_q[8]};
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 8'h00;
            quiet_q <= 9'h000;
        end else begin
            ctrl_q <= ctrl_d;
            quiet_q <= quiet_d;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    a_fifo_limit_set: assert property (
        rds && ja && inm && $stable(ctrl_q) && $stable(fifo_fill) |=> rdata[3])
        else $error("fifo limit not shown");
    a_fifo_limit_clear: assert property (
        rds && ja && !inm && $stable(ctrl_q) && $stable(fifo_fill) |=> !rdata[3])
        else $error("fifo limit not cleared");
    a_fifo_jitter_off: assert property (
        rds && !ja && $stable(ctrl_q) |=> !rdata[3])
        else $error("fifo limit with jitter off");
    a_drive_clear_active: assert property (
        (ctrl_q[5] && pads)[*3] ##1 (ctrl_q[5] && pads && rds) |=> !rdata[0])
        else $error("drive alarm kept under activity");
    a_drive_set_quiet: assert property (
        rds && quiet_q >= 9'h083 |=> rdata[0])
        else $error("drive alarm missing");
    a_los_wired_or: assert property (
        (analog_los_pin && ds3)[*7] ##1 (analog_los_pin && ds3 && rds) |=> rdata[1])
        else $error("analog loss not shown");
    a_los_e3_set: assert property (
        (g775_los_pin && e3)[*7] ##1 (g775_los_pin && e3 && rds) |=> rdata[1])
        else $error("e3 loss not shown");
    a_los_e3_clear: assert property (
        (!g775_los_pin && e3)[*7] ##1 (!g775_los_pin && e3 && rds) |=> !rdata[1])
        else $error("e3 loss without detector");
endmodule
bind liu_channel_alarm_monitor alarm_monitor_sva u_sva (.mclk, .resetn, .addr, .wdata, .wr,
    .rd, .rdata, .fifo_fill, .analog_los_pin, .g775_los_pin, .tx_bit_tick,
    .tx_line_positive_out, .tx_line_negative_out);

//--- verification/line_side_model.sv
// Purpose: Line-side stand-in for recovered ticks, pads and monitor pins.
// Assumes: Bit ticks and the E3 reference run every cycle.
// Notes:   A gap drops one tick per period, so deviations are exact counts.
module line_side_model (
    input wire logic mclk, // clock
    input wire logic resetn, // reset
    input wire logic [9:0] rec_gap, // drop period, 0 none
    input wire logic tx_quiet, // stop pad pulses
    input wire logic mon_cut, // monitor unwired
    input wire logic [1:0] rx_mode, // 0 none, 1 all, 2 half
    output logic rec_tick, // recovered tick
    output logic synth_tick, // synth tick, gap 50
    output logic rx_pulse, // pulse in bit
    output logic tx_line_positive_out, // pad
    output logic tx_line_negative_out, // pad
    output logic mon_pos_pin, // monitor
    output logic mon_neg_pin // monitor
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] cnt_q, cnt_d;
    logic ph_q;
    assign cnt_d = (cnt_q == 10'h3E7) ? 10'h000 : cnt_q + 10'h001;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 10'h000;
            ph_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ph_q <= !ph_q;
        end
    end
    assign rec_tick = rec_gap == 10'h000 || cnt_q % rec_gap != 10'h000;
    assign synth_tick = cnt_q % 10'h032 != 10'h000;
    assign rx_pulse = rx_mode == 2'h1 || (rx_mode == 2'h2 && ph_q);
    // Marks alternate polarity, each held four cycles so that the
    // monitor synchronisers see a settled level
    assign tx_line_positive_out = !tx_quiet && cnt_q[2];
    assign tx_line_negative_out = !tx_quiet && !cnt_q[2];
    // An unwired monitor input is taken as idle low
    assign mon_pos_pin = !mon_cut && tx_line_positive_out;
    assign mon_neg_pin = !mon_cut && tx_line_negative_out;
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the channel alarm monitor.
// Assumes: Bit ticks and the E3 reference run every cycle; DS3 and
//          STS-1 references come from the line model.
// Notes:   Lock checks wait two windows of 2000 reference ticks.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ST = alarm_pkg::OFF_STATUS;
    localparam logic [7:0] CT = alarm_pkg::OFF_CTRL;
    localparam logic [7:0] IS = alarm_pkg::OFF_IRQ_STAT;
    localparam logic [7:0] IM = alarm_pkg::OFF_IRQ_MASK;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] fifo_fill = 6'h08;
    logic analog_los_pin = 1'b0;
    logic g775_los_pin = 1'b0;
    logic [9:0] rec_gap = 10'h000;
    logic tx_quiet = 1'b0;
    logic mon_cut = 1'b0;
    logic [1:0] rx_mode = 2'h1;
    logic [7:0] rdata;
    logic irq, rec_tick, synth_tick, rx_pulse, tx_line_positive_out, tx_line_negative_out;
    logic mon_pos_pin, mon_neg_pin;
    int failures = 0;
    int compares = 0;
    int i;
    int sz;
    logic [9:0] gaps [4] = '{10'h000, 10'h0FA, 10'h0C8, 10'h032};
    always #50 mclk = !mclk;
    line_side_model u_line (.mclk, .resetn, .rec_gap, .tx_quiet, .mon_cut, .rx_mode,
        .rec_tick, .synth_tick, .rx_pulse, .tx_line_positive_out, .tx_line_negative_out,
        .mon_pos_pin, .mon_neg_pin);
    liu_channel_alarm_monitor u_dut (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .irq,
        .fifo_fill, .rec_tick, .e3_reference_clock(1'b1), .ds3_reference_clock(synth_tick),
        .sts1_reference_clock(rec_tick), .synth_tick, .rx_bit_tick(1'b1), .rx_pulse,
        .analog_los_pin, .g775_los_pin, .tx_bit_tick(1'b1), .tx_line_positive_out,
        .tx_line_negative_out, .mon_pos_pin, .mon_neg_pin);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // The extra cycle lets status catch up with inputs changed just before
    task automatic rcmp(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        idle(2);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #50;
        check(rdata & m, e);
    endtask
    task automatic chk_irq(input logic e);
        idle(2);
        #50;
        check({7'h00, irq}, {7'h00, e});
    endtask
    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        idle(6);
        resetn <= 1'b1;
        rcmp(ST, 8'hFF, 8'h00);
        wreg(ST, 8'hFF);
        rcmp(ST, 8'hFF, 8'h00);
        $display("test reset done");
        for (sz = 16; sz <= 32; sz += 16) begin
            wreg(CT, (sz == 32) ? 8'h03 : 8'h01);
            for (i = 0; i <= sz; i++) begin
                @(posedge mclk);
                fifo_fill <= i[5:0];
                rcmp(ST, 8'h08, (i <= 2 || i >= sz - 2) ? 8'h08 : 8'h00);
            end
        end
        wreg(CT, 8'h00);
        rcmp(ST, 8'h08, 8'h00);
        $display("test fifo limit done");
        wreg(CT, 8'h20);
        tx_quiet <= 1'b1;
        idle(118);
        rcmp(ST, 8'h01, 8'h00);
        idle(14);
        rcmp(ST, 8'h01, 8'h01);
        rcmp(IS, 8'h01, 8'h01);
        wreg(IM, 8'h01);
        chk_irq(1'b1);
        wreg(IM, 8'h00);
        chk_irq(1'b0);
        @(posedge mclk);
        tx_quiet <= 1'b0;
        idle(2);
        rcmp(ST, 8'h01, 8'h00);
        wreg(IS, 8'h01);
        rcmp(IS, 8'h01, 8'h00);
        wreg(IM, 8'h01);
        chk_irq(1'b0);
        wreg(CT, 8'h00);
        mon_cut <= 1'b1;
        idle(140);
        rcmp(ST, 8'h01, 8'h01);
        @(posedge mclk);
        mon_cut <= 1'b0;
        idle(8);
        rcmp(ST, 8'h01, 8'h00);
        $display("test drive monitor done");
        wreg(CT, 8'h04);
        analog_los_pin <= 1'b1;
        idle(8);
        rcmp(ST, 8'h22, 8'h02);
        @(posedge mclk);
        analog_los_pin <= 1'b0;
        rx_mode <= 2'h0;
        idle(150);
        rcmp(ST, 8'h22, 8'h00);
        idle(16);
        rcmp(ST, 8'h22, 8'h22);
        @(posedge mclk);
        rx_mode <= 2'h2;
        idle(80);
        rcmp(ST, 8'h22, 8'h00);
        wreg(CT, 8'h00);
        analog_los_pin <= 1'b1;
        idle(8);
        rcmp(ST, 8'h02, 8'h00);
        @(posedge mclk);
        g775_los_pin <= 1'b1;
        idle(8);
        rcmp(ST, 8'h02, 8'h02);
        $display("test loss of signal done");
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            rec_gap <= gaps[i];
            idle(4100);
            rcmp(ST, 8'h04, (i >= 2) ? 8'h04 : 8'h00);
        end
        wreg(CT, 8'h10);
        idle(4200);
        rcmp(ST, 8'h04, 8'h00);
        @(posedge mclk);
        rec_gap <= 10'h000;
        idle(4200);
        rcmp(ST, 8'h04, 8'h04);
        wreg(CT, 8'h08);
        idle(4200);
        rcmp(ST, 8'h04, 8'h00);
        wreg(CT, 8'h04);
        idle(4200);
        rcmp(ST, 8'h04, 8'h04);
        $display("test loss of lock done");
        give_verdict();
    end
    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule

//--- verilog/alarm_pkg.sv
// Purpose: Shared constants for the channel alarm monitor.
// Assumes: 10 MHz mclk, register port with 8-bit address and data.
// Notes:   Offsets are word indexes on the plain register port.
package alarm_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h01;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h02;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
    // ----------------------------------------
    // Status bit positions
    // ----------------------------------------
    localparam int BIT_DMO = 0;
    localparam int BIT_LOS = 1;
    localparam int BIT_LOL = 2;
    localparam int BIT_FL = 3;
    localparam int BIT_ALOS = 4;
    localparam int BIT_DLOS = 5;
    // ----------------------------------------
    // Control bit positions, rate codes and reset values
    // ----------------------------------------
    localparam int CB_JA_EN = 0;
    localparam int CB_FIFO32 = 1;
    localparam int CB_RATE_LO = 2;
    localparam int CB_SFM = 4;
    localparam int CB_INT_MON = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] RATE_E3 = 2'h0;
    localparam logic [1:0] RATE_DS3 = 2'h1;
    localparam logic [1:0] RATE_STS1 = 2'h2;
    // ----------------------------------------
    // Alarm thresholds
    // ----------------------------------------
    localparam logic [5:0] FIFO_MARGIN = 6'h02;
    localparam logic [5:0] FIFO_SMALL = 6'h10;
    localparam logic [5:0] FIFO_LARGE = 6'h20;
    localparam logic [11:0] LOL_WINDOW = 12'h7D0;
    localparam logic [11:0] LOL_DEVIATION = 12'h00A;
    localparam logic [7:0] DLOS_ZEROS = 8'hA0;
    localparam logic [5:0] DLOS_WINDOW = 6'h20;
    localparam logic [5:0] DLOS_CLR_ONES = 6'h0B;
    localparam logic [7:0] DMO_ZEROS = 8'h80;
endpackage

//--- verilog/liu_channel_alarm_monitor.sv
// Purpose: Alarm detection and status reporting for one line channel.
// Assumes: Bit ticks and reference ticks are one-cycle mclk enables
//          made by the clock logic; analog detector and monitor pins
//          are asynchronous.
// Notes:   Status bits are live levels; interrupt bits latch rises.
//
// Added by the designer: the register offsets and strobed register access.

// Functional notes
// RL1: The FIFO limit alarm rises while fill is within two of empty or full.
// RL2: The FIFO limit alarm falls as soon as fill leaves that margin.
// RL3: The FIFO limit alarm stays low while the jitter attenuator is off.
// RL4: Status bit 3 is read-only, resets to 0 and shows the FIFO limit alarm.
// RL5: Loss of lock is declared at 0.5% or more deviation from the rate reference.
// RL6: In single-frequency mode the synthesized clock is the lock reference.
// RL7: Status bit 2 is read-only, resets to 0 and shows loss of lock.
// RL8: For DS3 and STS-1 loss of signal is digital OR analog, shown on bit 1.
// RL9: For E3 loss of signal follows the standard-compliant detector.
// RL10: The drive monitor alarm rises after 128 bit periods without pulses.
// RL11: Any bipolar activity clears the drive monitor alarm at once; bit 0 shows it.
// RL12: Drive pulses are watched at the output pads or at the monitor inputs.
// RL13: The digital detector declares after 160 bit periods without pulses.
// RL14: The digital detector clears once pulse density reaches 33%.
// RL15: Control bit set selects internal pad monitoring, clear selects inputs.
// RL16: Every alarm is brought into the mclk domain before it is reported.
module liu_channel_alarm_monitor (
    input wire logic mclk,                  // 10 MHz clock
    input wire logic resetn,                // async reset, active low
    input wire logic [7:0] addr,            // register index
    input wire logic [7:0] wdata,           // write data
    input wire logic wr,                    // write strobe
    input wire logic rd,                    // read strobe
    output logic [7:0] rdata,               // read data, cycle after rd
    output logic irq,                       // level interrupt
    input wire logic [5:0] fifo_fill,       // jitter FIFO fill in bits
    input wire logic rec_tick,              // recovered clock tick
    input wire logic e3_reference_clock,    // E3 reference tick
    input wire logic ds3_reference_clock,   // DS3 reference tick
    input wire logic sts1_reference_clock,  // STS-1 reference tick
    input wire logic synth_tick,            // synthesized line clock tick
    input wire logic rx_bit_tick,           // receive bit period enable
    input wire logic rx_pulse,              // pulse seen in this bit
    input wire logic analog_los_pin,        // analog detector, async
    input wire logic g775_los_pin,          // E3 detector, async
    input wire logic tx_bit_tick,           // transmit bit period enable
    input wire logic tx_line_positive_out,  // positive drive at pad
    input wire logic tx_line_negative_out,  // negative drive at pad
    input wire logic mon_pos_pin,           // external monitor, async
    input wire logic mon_neg_pin            // external monitor, async
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [3:0] pins;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] stab_q;
    logic [3:0] stab_d;

    assign pins = {mon_neg_pin, mon_pos_pin, g775_los_pin, analog_los_pin};

    // A pin level counts only after two late stages agree
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            stab_q <= 4'h0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d; // [RL16]
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic ja_en;
    logic fifo32;
    logic [1:0] rate;
    logic single_frequency_mode;
    logic int_mon;

    assign ja_en = ctrl_q[alarm_pkg::CB_JA_EN];
    assign fifo32 = ctrl_q[alarm_pkg::CB_FIFO32];
    assign rate = ctrl_q[alarm_pkg::CB_RATE_LO +: 2];
    assign single_frequency_mode = ctrl_q[alarm_pkg::CB_SFM];
    assign int_mon = ctrl_q[alarm_pkg::CB_INT_MON];

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr && addr == alarm_pkg::OFF_CTRL) begin
            ctrl_d = wdata & 8'h3F;
        end
    end

    // ----------------------------------------
    // FIFO limit
    // ----------------------------------------
    logic fl_d;
    logic [5:0] fifo_top;

    always_comb begin
        fifo_top = fifo32 ? alarm_pkg::FIFO_LARGE : alarm_pkg::FIFO_SMALL;
        // Level tracks fill in both directions, no hysteresis
        fl_d = ja_en && // [RL3]
            (fifo_fill <= alarm_pkg::FIFO_MARGIN || // [RL1] [RL2]
             fifo_fill >= fifo_top - alarm_pkg::FIFO_MARGIN);
    end

    // ----------------------------------------
    // Loss of lock
    // ----------------------------------------
    logic ref_tick;
    logic [11:0] win_q;
    logic [11:0] win_d;
    logic [11:0] rcnt_q;
    logic [11:0] rcnt_d;
    logic lol_q;
    logic lol_d;
    logic [11:0] dev;

    always_comb begin
        unique case (rate)
            alarm_pkg::RATE_DS3: ref_tick = ds3_reference_clock;
            alarm_pkg::RATE_STS1: ref_tick = sts1_reference_clock;
            default: ref_tick = e3_reference_clock;
        endcase
        if (single_frequency_mode) begin
            ref_tick = synth_tick; // [RL6]
        end
        win_d = win_q;
        rcnt_d = rcnt_q;
        lol_d = lol_q;
        if (rec_tick && rcnt_q != 12'hFFF) begin
            rcnt_d = rcnt_q + 12'h001;
        end
        // Both counts cover the same cycles, the closing one included
        dev = (rcnt_d > alarm_pkg::LOL_WINDOW) ? rcnt_d - alarm_pkg::LOL_WINDOW
            : alarm_pkg::LOL_WINDOW - rcnt_d;
        if (ref_tick) begin
            win_d = win_q + 12'h001;
            if (win_d == alarm_pkg::LOL_WINDOW) begin
                // 10 in 2000 reference periods is 0.5%
                lol_d = dev >= alarm_pkg::LOL_DEVIATION; // [RL5]
                win_d = 12'h000;
                rcnt_d = 12'h000;
            end
        end
    end

    // ----------------------------------------
    // Digital loss of signal
    // ----------------------------------------
    logic [7:0] zrun_q;
    logic [7:0] zrun_d;
    logic [5:0] dwin_q;
    logic [5:0] dwin_d;
    logic [5:0] ones_q;
    logic [5:0] ones_d;
    logic dlos_q;
    logic dlos_d;
    logic los_d;

    always_comb begin
        zrun_d = zrun_q;
        dwin_d = dwin_q;
        ones_d = ones_q;
        dlos_d = dlos_q;
        if (rx_bit_tick) begin
            if (rx_pulse) begin
                zrun_d = 8'h00;
            end else if (zrun_q != alarm_pkg::DLOS_ZEROS) begin
                zrun_d = zrun_q + 8'h01;
            end
            if (zrun_d == alarm_pkg::DLOS_ZEROS) begin
                dlos_d = 1'b1; // [RL13]
            end
            // Clearing judges density over fixed windows while declared
            dwin_d = dwin_q + 6'h01;
            ones_d = ones_q + {5'h00, rx_pulse};
            if (dwin_d == alarm_pkg::DLOS_WINDOW) begin
                if (dlos_q && ones_d >= alarm_pkg::DLOS_CLR_ONES) begin
                    dlos_d = 1'b0; // [RL14]
                    zrun_d = 8'h00;
                end
                dwin_d = 6'h00;
                ones_d = 6'h00;
            end
        end
        if (rate == alarm_pkg::RATE_E3) begin
            los_d = stab_q[1]; // [RL9]
        end else begin
            los_d = dlos_q || stab_q[0]; // [RL8]
        end
    end

    // ----------------------------------------
    // Transmit drive monitor
    // ----------------------------------------
    logic [7:0] dcnt_q;
    logic [7:0] dcnt_d;
    logic dmo_q;
    logic dmo_d;
    logic tx_act;

    always_comb begin
        if (int_mon) begin
            tx_act = tx_line_positive_out || tx_line_negative_out; // [RL12] [RL15]
        end else begin
            tx_act = stab_q[2] || stab_q[3]; // [RL12] [RL15]
        end
        dcnt_d = dcnt_q;
        dmo_d = dmo_q;
        if (tx_act) begin
            dcnt_d = 8'h00;
            dmo_d = 1'b0; // [RL11]
        end else if (tx_bit_tick && dcnt_q != alarm_pkg::DMO_ZEROS) begin
            dcnt_d = dcnt_q + 8'h01;
            if (dcnt_d == alarm_pkg::DMO_ZEROS) begin
                dmo_d = 1'b1; // [RL10]
            end
        end
    end

    // ----------------------------------------
    // Status, interrupts and read port
    // ----------------------------------------
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [3:0] ist_q;
    logic [3:0] ist_d;
    logic [3:0] imask_q;
    logic [3:0] imask_d;
    logic [7:0] rdata_d;
    logic irq_d;

    always_comb begin
        stat_d = alarm_pkg::STATUS_RESET;
        stat_d[alarm_pkg::BIT_FL] = fl_d; // [RL4]
        stat_d[alarm_pkg::BIT_LOL] = lol_q; // [RL7]
        stat_d[alarm_pkg::BIT_LOS] = los_d; // [RL8]
        stat_d[alarm_pkg::BIT_DMO] = dmo_q; // [RL11]
        stat_d[alarm_pkg::BIT_ALOS] = stab_q[0];
        stat_d[alarm_pkg::BIT_DLOS] = dlos_q;
        imask_d = imask_q;
        ist_d = ist_q;
        if (wr && addr == alarm_pkg::OFF_IRQ_MASK) begin
            imask_d = wdata[3:0];
        end
        if (wr && addr == alarm_pkg::OFF_IRQ_STAT) begin
            ist_d = ist_q & ~wdata[3:0];
        end
        // A new rise wins over a clear in the same cycle
        ist_d = ist_d | (stat_d[3:0] & ~stat_q[3:0]);
        irq_d = |(ist_d & imask_d);
        rdata_d = 8'h00;
        if (rd) begin
            unique case (addr)
                alarm_pkg::OFF_STATUS: rdata_d = stat_q;
                alarm_pkg::OFF_CTRL: rdata_d = ctrl_q;
                alarm_pkg::OFF_IRQ_STAT: rdata_d = {4'h0, ist_q};
                alarm_pkg::OFF_IRQ_MASK: rdata_d = {4'h0, imask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= alarm_pkg::CTRL_RESET;
            win_q <= 12'h000;
            rcnt_q <= 12'h000;
            lol_q <= 1'b0;
            zrun_q <= 8'h00;
            dwin_q <= 6'h00;
            ones_q <= 6'h00;
            dlos_q <= 1'b0;
            dcnt_q <= 8'h00;
            dmo_q <= 1'b0;
            stat_q <= alarm_pkg::STATUS_RESET;
            ist_q <= 4'h0;
            imask_q <= 4'h0;
            rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            win_q <= win_d;
            rcnt_q <= rcnt_d;
            lol_q <= lol_d;
            zrun_q <= zrun_d;
            dwin_q <= dwin_d;
            ones_q <= ones_d;
            dlos_q <= dlos_d;
            dcnt_q <= dcnt_d;
            dmo_q <= dmo_d;
            stat_q <= stat_d; // [RL16]
            ist_q <= ist_d;
            imask_q <= imask_d;
            rdata <= rdata_d;
            irq <= irq_d;
        end
    end
endmodule
